// >>> bench/irc_mix_model.sv
// Stand-in for the mixing core: strobed sample sources at two rates
`timescale 1ns/1ps
`default_nettype none
module irc_mix_model #(
  parameter int HP    = 4,
  parameter int RATIO = 1
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  output var  irc_pkg::irc_sample_type low_in  [2][2],
  output var  irc_pkg::irc_sample_type high_in [2][2]
);
  logic [15:0] cyc_r;
  logic [23:0] pat_r;
  logic        hi_tick;
  logic        lo_tick;
  ////////////////////////////////////////
  // Data flips between two words every cycle; with even HP every strobe sees the same word
  always_ff @(posedge aclk) begin
    cyc_r <= aresetn ? cyc_r + 16'h0001 : 16'h0000;
    pat_r <= aresetn ? ~pat_r + 24'h000001 : 24'h5a5a5a;
  end
  // Low strobe on every RATIO-th high strobe, both at the converter rates
  assign hi_tick = aresetn && (int'(cyc_r) % HP == 0);
  assign lo_tick = aresetn && (int'(cyc_r) % (HP * RATIO) == 0);
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      for (int p = 0; p < 2; p++) begin
        high_in[c][p] = '{valid: hi_tick, data: pat_r};
        low_in[c][p]  = '{valid: lo_tick, data: ~pat_r};
      end
    end
  end
endmodule : irc_mix_model
`default_nettype wire

// >>> bench/irc_top_props.sv
// Port-level assertions for the rate converter pair
`timescale 1ns/1ps
`default_nettype none
module irc_top_props (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic [1:0]              s_axi_bresp,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire irc_pkg::irc_sample_type high_in  [2][2],
  input wire irc_pkg::irc_sample_type high_out [2][2],
  input wire irc_pkg::irc_sample_type low_out  [2][2],
  input wire logic                    underclock_err
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // Bus answers hold until the master takes them
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  // Error flag is sticky and only a completed write can raise or clear it;
  // the write answer rises on the same edge as the flag rises, and one edge before it falls
  AST_ERR_KEEP: assert property (
    underclock_err && !s_axi_bvalid |=> underclock_err)
    else $error("error flag lost");
  AST_ERR_CAUSE: assert property (
    $rose(underclock_err) |-> s_axi_bvalid)
    else $error("error flag without write");
  // No output sample unless a high-rate strobe came the cycle before
  AST_INT1: assert property (
    !high_in[0][0].valid |=> !high_out[0][0].valid) else $error("stray int1");
  AST_INT2: assert property (
    !high_in[1][1].valid |=> !high_out[1][1].valid) else $error("stray int2");
  AST_DEC1: assert property (
    !high_in[0][0].valid |=> !low_out[0][0].valid) else $error("stray dec1");
  AST_DEC2: assert property (
    !high_in[1][1].valid |=> !low_out[1][1].valid) else $error("stray dec2");
endmodule : irc_top_props
bind irc_top irc_top_props u_props (.aclk, .aresetn,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .high_in, .high_out, .low_out, .underclock_err);
`default_nettype wire

// >>> bench/irc_top_tb.sv
// Self-checking bench for the isochronous rate converter pair
`timescale 1ns/1ps
`default_nettype none
module irc_top_tb;
  logic                    aclk, aresetn, underclock_err;
  logic [13:0]             s_axi_awaddr, s_axi_araddr;
  logic [31:0]             s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]              s_axi_wstrb;
  logic [1:0]              s_axi_bresp, s_axi_rresp, rs;
  logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                    s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                    s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                    s_axi_rready;
  logic [4:0]              mix_load;
  irc_pkg::irc_sample_type low_in [2][2], high_in [2][2];
  irc_pkg::irc_sample_type low_out [2][2], high_out [2][2];
  int                      fail_count = 0, checks = 0, cyc = 0, hv, lv, nz;
  ////////////////////////////////////////
  irc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .mix_load, .low_in, .high_in, .high_out, .low_out, .underclock_err);
  irc_mix_model #(.HP(4), .RATIO(1)) u_mix (.aclk, .aresetn, .low_in, .high_in);
  // 20 MHz clock; the ceiling is far above the few hundred cycles needed
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Address and data go out together; each drops once taken
  task automatic axi_wr(input logic [11:0] idx, input logic [15:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
  endtask : axi_wr
  task automatic rchk(input logic [11:0] idx, input logic [31:0] m, e);
    @(posedge aclk);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    chk(rd & m, e);
  endtask : rchk
  // Counts converter 1 output strobes and non-silent words over 40 cycles
  task automatic watch;
    hv = 0;
    lv = 0;
    nz = 0;
    // Decimated words stand until the next strobe; let old ones drain
    repeat (8) @(posedge aclk);
    repeat (40) begin
      @(posedge aclk);
      #1;
      if (high_out[0][0].valid === 1'b1) hv++;
      if (low_out[0][0].valid === 1'b1) lv++;
      if (high_out[0][0].data !== 24'h0 || low_out[0][0].data !== 24'h0) nz++;
    end
  endtask : watch
  task automatic t_codes;
    logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9};
    rchk(irc_pkg::IRC_IDX_C1_HIGH, 32'hffffffff, 32'h0);
    rchk(irc_pkg::IRC_IDX_C1_LOW, 32'hffffffff, 32'h0);
    rchk(irc_pkg::IRC_IDX_C1_EN, 32'hffffc301, 32'h0);
    foreach (codes[i]) begin
      axi_wr(irc_pkg::IRC_IDX_C2_HIGH, {1'b0, codes[i], 11'h000});
      axi_wr(irc_pkg::IRC_IDX_C2_LOW, {1'b0, codes[i], 11'h000});
      rchk(irc_pkg::IRC_IDX_C2_HIGH, 32'h7800, {17'h0, codes[i], 11'h0});
      rchk(irc_pkg::IRC_IDX_C2_LOW, 32'h7800, {17'h0, codes[i], 11'h0});
    end
  endtask : t_codes
  task automatic t_stream;
    axi_wr(irc_pkg::IRC_IDX_C1_EN, 16'hc301);
    rchk(irc_pkg::IRC_IDX_C1_EN, 32'hffff, 32'hc301);
    watch();
    chk(hv, 10);
    chk(32'(nz > 0), 32'h1);
    chk(lv, 10);
  endtask : t_stream
  // Five paths plus one load unit fill the budget exactly; a sixth overflows
  task automatic t_refuse;
    @(posedge aclk);
    mix_load <= 5'h01;
    axi_wr(irc_pkg::IRC_IDX_BUDGET, 16'h0904);
    axi_wr(irc_pkg::IRC_IDX_C2_EN, 16'h8000);
    chk(underclock_err, 1'b0);
    axi_wr(irc_pkg::IRC_IDX_C2_EN, 16'hc000);
    rchk(irc_pkg::IRC_IDX_C2_EN, 32'hffff, 32'h8000);
    chk(underclock_err, 1'b1);
    watch();
    chk(hv, 10);
    chk(32'(nz > 0), 32'h1);
    axi_wr(irc_pkg::IRC_IDX_STATUS, 16'h0001);
    chk(rs, irc_pkg::IRC_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(underclock_err, 1'b0);
  endtask : t_refuse
  task automatic t_bad;
    rchk(irc_pkg::IRC_IDX_BUDGET + 12'h001, 32'h0, 32'h0);
    chk(rs, irc_pkg::IRC_RESP_SLVERR);
    axi_wr(irc_pkg::IRC_IDX_C1_HIGH, 16'h1800); // Code 3 is reserved
    watch();
    chk(nz, 0);
    axi_wr(irc_pkg::IRC_IDX_C1_HIGH, 16'h4000); // Async high over core low
    watch();
    chk(nz, 0);
  endtask : t_bad
  task automatic wrap_up;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, aresetn} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    mix_load = 5'h00;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_codes();
    t_stream();
    t_refuse();
    t_bad();
    wrap_up();
  end
endmodule : irc_top_tb
`default_nettype wire

// >>> core/irc_top.sv
// Two isochronous rate converters with AXI4-Lite control
`timescale 1ns/1ps
`default_nettype none
module irc_top (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [13:0]             s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output var  logic                    s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output var  logic                    s_axi_wready,
  output var  logic [1:0]              s_axi_bresp,
  output var  logic                    s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [13:0]             s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output var  logic                    s_axi_arready,
  output var  logic [31:0]             s_axi_rdata,
  output var  logic [1:0]              s_axi_rresp,
  output var  logic                    s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic [4:0]              mix_load,
  input  wire irc_pkg::irc_sample_type low_in   [2][2],
  input  wire irc_pkg::irc_sample_type high_in  [2][2],
  output var  irc_pkg::irc_sample_type high_out [2][2],
  output var  irc_pkg::irc_sample_type low_out  [2][2],
  output var  logic                    underclock_err
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [15:0] high_sel_r [2];
  logic [15:0] low_sel_r  [2];
  logic [15:0] path_en_r  [2];
  logic [4:0]  core_rate_r  [3];
  logic [4:0]  async_rate_r [2];
  logic        err_r;
  logic        aw_have_r, w_have_r, ar_busy_r;
  logic [13:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  // Rate code to rate in 8 kHz units; zero marks a reserved code
  function automatic logic [4:0] code_rate(input logic [3:0] c,
      input logic [4:0] c0, input logic [4:0] c1, input logic [4:0] c2,
      input logic [4:0] a0, input logic [4:0] a1);
    logic [4:0] r;
    r = 5'h00;
    if (c == irc_pkg::IRC_CODE_CORE1)       r = c0;
    else if (c == irc_pkg::IRC_CODE_CORE2)  r = c1;
    else if (c == irc_pkg::IRC_CODE_CORE3)  r = c2;
    else if (c == irc_pkg::IRC_CODE_ASYNC1) r = a0;
    else if (c == irc_pkg::IRC_CODE_ASYNC2) r = a1;
    return r;
  endfunction : code_rate

  // Paths on in an enable word
  function automatic logic [2:0] path_count(input logic [15:0] e);
    return 3'({2'b00, e[irc_pkg::IRC_INT1_BIT]} + e[irc_pkg::IRC_INT2_BIT]
              + e[irc_pkg::IRC_DEC1_BIT] + e[irc_pkg::IRC_DEC2_BIT]);
  endfunction : path_count

  // Byte address to register index, word aligned
  function automatic logic [11:0] word_idx(input logic [13:0] a);
    return a[13:2];
  endfunction : word_idx

  ////////////////////////////////////////////////////////////////////////////
  // Per-converter rate decode, domain and ratio checks
  irc_pkg::irc_rates_type rates [2];
  logic [2:0]  ratio [2];
  logic [3:0]  notch_k [2];
  genvar gi, gp;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_conv
      wire [3:0] hc = high_sel_r[gi][irc_pkg::IRC_SEL_MSB:irc_pkg::IRC_SEL_LSB];
      wire [3:0] lc = low_sel_r[gi][irc_pkg::IRC_SEL_MSB:irc_pkg::IRC_SEL_LSB];
      wire [4:0] hr = code_rate(hc, core_rate_r[0], core_rate_r[1],
                                core_rate_r[2], async_rate_r[0],
                                async_rate_r[1]);
      wire [4:0] lr = code_rate(lc, core_rate_r[0], core_rate_r[1],
                                core_rate_r[2], async_rate_r[0],
                                async_rate_r[1]);
      // Same domain when the async flag bit matches
      wire same_dom = (hc[3] == lc[3]);
      wire in_rng = (lr >= irc_pkg::IRC_MIN_RATE)
                 && (hr <= irc_pkg::IRC_MAX_RATE);
      wire [7:0] m2 = 8'({lr, 1'b0});
      wire [7:0] m3 = 8'(lr * 3);
      wire [7:0] m4 = 8'({lr, 2'b00});
      wire [7:0] m5 = 8'(lr * 5);
      wire [7:0] m6 = 8'(lr * 6);
      wire [7:0] h8 = {3'b000, hr};
      // Integer ratio 1 to 6, larger rate in the high field
      wire [2:0] rt = (h8 == {3'b000, lr}) ? 3'h1 : (h8 == m2) ? 3'h2 :
                      (h8 == m3) ? 3'h3 : (h8 == m4) ? 3'h4 :
                      (h8 == m5) ? 3'h5 : (h8 == m6) ? 3'h6 : 3'h0;
      assign ratio[gi] = rt;
      wire ok_w = (hr != 5'h00) && (lr != 5'h00) && same_dom
               && in_rng && (rt != 3'h0);
      assign rates[gi] = '{ok: ok_w, low: lr, high: hr};
      // Notch tuning index picked from the low rate, nothing to program
      assign notch_k[gi] = lr[4:1];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Clock budget: cycles demanded versus cycles per base sample
  logic [15:0] budget_r;
  wire  [15:0] cyc_avail = 16'(irc_pkg::IRC_CYC_PER_BASE);
  wire  [4:0]  paths_on  = 5'(path_count(path_en_r[0]))
                         + 5'(path_count(path_en_r[1]));

  ////////////////////////////////////////////////////////////////////////////
  // AXI write decode
  wire        aw_take = s_axi_awvalid && s_axi_awready;
  wire        w_take  = s_axi_wvalid && s_axi_wready;
  wire        aw_now  = aw_have_r || aw_take;
  wire        w_now   = w_have_r || w_take;
  wire [13:0] wa      = aw_have_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wd      = w_have_r ? wdata_r : s_axi_wdata;
  wire [3:0]  ws      = w_have_r ? wstrb_r : s_axi_wstrb;
  wire        do_wr   = aw_now && w_now && !s_axi_bvalid;
  wire [11:0] widx    = word_idx(wa);
  wire [15:0] wmask   = {{8{ws[1]}}, {8{ws[0]}}};
  // Status takes a write (error clear), so it answers OKAY as well
  wire        wr_known = (widx >= irc_pkg::IRC_IDX_C1_HIGH)
                      && (widx <= irc_pkg::IRC_IDX_BUDGET);

  // Per-converter enable write with clock check
  logic [15:0] en_nxt [2];
  logic        refuse [2];
  generate
    for (gi = 0; gi < 2; gi++) begin : g_en
      wire [11:0] my_idx = (gi == 0) ? irc_pkg::IRC_IDX_C1_EN
                                     : irc_pkg::IRC_IDX_C2_EN;
      wire        hit = do_wr && (widx == my_idx);
      wire [15:0] req = ((path_en_r[gi] & ~wmask) | (wd[15:0] & wmask))
                      & irc_pkg::IRC_EN_MASK;
      // Newly requested paths: rising enable bits only
      wire [15:0] rise = req & ~path_en_r[gi] & 16'hc300;
      wire [4:0]  add  = 5'(path_count(rise));
      // Each path costs a fixed slice whatever its rate, plus the mixing load and the budget word
      wire [15:0] need = 16'((paths_on + add)
                       * irc_pkg::IRC_CYC_PER_PATH)
                       + 16'({mix_load, 5'h00})
                       + budget_r;
      wire        short = (add != 5'h00) && (need > cyc_avail);
      assign refuse[gi] = hit && short;
      // Refused write keeps the word as it was, running paths untouched
      assign en_nxt[gi] = !hit ? path_en_r[gi]
                        : short ? path_en_r[gi]
                        : req;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // AXI read decode
  wire [11:0] ridx = word_idx(s_axi_araddr);
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (ridx)
      irc_pkg::IRC_IDX_C1_HIGH: rd_mux = {16'h0000, high_sel_r[0]};
      irc_pkg::IRC_IDX_C1_LOW:  rd_mux = {16'h0000, low_sel_r[0]};
      irc_pkg::IRC_IDX_C1_EN:   rd_mux = {16'h0000, path_en_r[0]};
      irc_pkg::IRC_IDX_C2_HIGH: rd_mux = {16'h0000, high_sel_r[1]};
      irc_pkg::IRC_IDX_C2_LOW:  rd_mux = {16'h0000, low_sel_r[1]};
      irc_pkg::IRC_IDX_C2_EN:   rd_mux = {16'h0000, path_en_r[1]};
      irc_pkg::IRC_IDX_STATUS:  rd_mux = {29'h0, rates[1].ok, rates[0].ok,
                                          err_r};
      irc_pkg::IRC_IDX_CORE_RATE: rd_mux = {17'h0, core_rate_r[2],
                                            core_rate_r[1], core_rate_r[0]};
      irc_pkg::IRC_IDX_ASYNC_RATE: rd_mux = {22'h0, async_rate_r[1],
                                             async_rate_r[0]};
      irc_pkg::IRC_IDX_BUDGET:  rd_mux = {16'h0000, budget_r};
      default: rd_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI handshake registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= irc_pkg::IRC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= irc_pkg::IRC_RESP_OKAY;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      ar_busy_r <= 1'b0;
      awaddr_r  <= 14'h0000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      // Each channel is held until both halves of the write are in
      s_axi_awready <= !aw_now && !s_axi_bvalid;
      s_axi_wready  <= !w_now && !s_axi_bvalid;
      if (aw_take) awaddr_r <= s_axi_awaddr;
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      aw_have_r <= aw_now && !do_wr;
      w_have_r  <= w_now && !do_wr;
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? irc_pkg::IRC_RESP_OKAY
                                 : irc_pkg::IRC_RESP_SLVERR;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Read: take the address, answer next cycle
      s_axi_arready <= !ar_busy_r && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        ar_busy_r    <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? irc_pkg::IRC_RESP_OKAY
                               : irc_pkg::IRC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        ar_busy_r    <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register file
  generate
    for (gi = 0; gi < 2; gi++) begin : g_reg
      wire [11:0] ih = (gi == 0) ? irc_pkg::IRC_IDX_C1_HIGH
                                 : irc_pkg::IRC_IDX_C2_HIGH;
      wire [11:0] il = (gi == 0) ? irc_pkg::IRC_IDX_C1_LOW
                                 : irc_pkg::IRC_IDX_C2_LOW;
      wire [15:0] fmask = 16'h7800 & wmask;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          high_sel_r[gi] <= irc_pkg::IRC_RST_SEL;
          low_sel_r[gi]  <= irc_pkg::IRC_RST_SEL;
          path_en_r[gi]  <= irc_pkg::IRC_RST_EN;
        end else begin
          if (do_wr && widx == ih)
            high_sel_r[gi] <= (high_sel_r[gi] & ~fmask) | (wd[15:0] & fmask);
          if (do_wr && widx == il)
            low_sel_r[gi] <= (low_sel_r[gi] & ~fmask) | (wd[15:0] & fmask);
          path_en_r[gi] <= en_nxt[gi];
        end
      end
    end
  endgenerate

  // Shared rate settings, budget and the sticky underclock flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_rate_r[0]  <= irc_pkg::IRC_RST_RATE;
      core_rate_r[1]  <= irc_pkg::IRC_RST_RATE;
      core_rate_r[2]  <= irc_pkg::IRC_RST_RATE;
      async_rate_r[0] <= irc_pkg::IRC_RST_RATE;
      async_rate_r[1] <= irc_pkg::IRC_RST_RATE;
      budget_r        <= irc_pkg::IRC_RST_BUDGET;
      err_r           <= 1'b0;
      underclock_err  <= 1'b0;
    end else begin
      if (do_wr && widx == irc_pkg::IRC_IDX_CORE_RATE) begin
        core_rate_r[0] <= wd[4:0];
        core_rate_r[1] <= wd[9:5];
        core_rate_r[2] <= wd[14:10];
      end
      if (do_wr && widx == irc_pkg::IRC_IDX_ASYNC_RATE) begin
        async_rate_r[0] <= wd[4:0];
        async_rate_r[1] <= wd[9:5];
      end
      if (do_wr && widx == irc_pkg::IRC_IDX_BUDGET) budget_r <= wd[15:0];
      // A refusal sets the flag; writing 1 to status bit 0 clears it,
      // and a refusal in the same cycle wins
      if (refuse[0] || refuse[1])
        err_r <= 1'b1;
      else if (do_wr && widx == irc_pkg::IRC_IDX_STATUS && wd[0])
        err_r <= 1'b0;
      underclock_err <= err_r || refuse[0] || refuse[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample paths: interpolation holds each low sample for ratio high slots,
  // decimation keeps one of each ratio high samples, notch smooths output
  generate
    for (gi = 0; gi < 2; gi++) begin : g_dp
      for (gp = 0; gp < 2; gp++) begin : g_path
        localparam int IB = (gp == 0) ? irc_pkg::IRC_INT1_BIT
                                      : irc_pkg::IRC_INT2_BIT;
        localparam int DB = (gp == 0) ? irc_pkg::IRC_DEC1_BIT
                                      : irc_pkg::IRC_DEC2_BIT;
        wire int_on = path_en_r[gi][IB] && rates[gi].ok;
        wire dec_on = path_en_r[gi][DB] && rates[gi].ok;
        // Notch tuned from the low rate; bypassed where no tuning exists
        wire notch  = path_en_r[gi][irc_pkg::IRC_NOTCH_BIT]
                   && (notch_k[gi] != 4'h0);
        logic [23:0] hold_r, dprev_r;
        logic [2:0]  dcnt_r;
        // Notch: average with previous sample when on; off passes direct
        wire [24:0] isum = {hold_r[23], hold_r} + {low_in[gi][gp].data[23],
                                                   low_in[gi][gp].data};
        wire [24:0] dsum = {dprev_r[23], dprev_r}
                         + {high_in[gi][gp].data[23], high_in[gi][gp].data};
        wire [23:0] iout = notch ? isum[24:1] : hold_r;
        wire [23:0] dout = notch ? dsum[24:1] : high_in[gi][gp].data;
        wire dlast = (dcnt_r + 3'h1 >= ratio[gi]);
        always_ff @(posedge aclk) begin
          if (!aresetn) begin
            hold_r   <= 24'h000000;
            dprev_r  <= 24'h000000;
            dcnt_r   <= 3'h0;
            high_out[gi][gp] <= '0;
            low_out[gi][gp]  <= '0;
          end else begin
            // Interpolation path from low rate to high rate
            if (low_in[gi][gp].valid) hold_r <= low_in[gi][gp].data;
            high_out[gi][gp].valid <= high_in[gi][gp].valid;
            high_out[gi][gp].data  <= int_on ? iout : 24'h000000;
            // Decimation path from high rate to low rate
            low_out[gi][gp].valid <= 1'b0;
            if (high_in[gi][gp].valid) begin
              dprev_r <= high_in[gi][gp].data;
              dcnt_r  <= dlast ? 3'h0 : dcnt_r + 3'h1;
              low_out[gi][gp].valid <= dlast;
              low_out[gi][gp].data  <= dec_on ? dout : 24'h000000;
            end
          end
        end
      end
    end
  endgenerate

endmodule : irc_top
`default_nettype wire

// >>> shared/irc_pkg.sv
// Package for the isochronous rate converter block: constants and carriers
// Operation
// - Two independent converters, each with paths between low and high rate.
// - On the main core clock each rate picks one of three core rates.
// - On the secondary clock the rates are the two async rate settings.
// - Rates from 8 kHz to 192 kHz; software keeps selections in range.
// - High rate is an integer multiple of low rate, ratios 1 to 6.
// - High select in bits 14:11; codes 0,1,2 core, 8,9 async; resets 0.
// - Low select in bits 14:11 of its register, same encoding, resets 0.
// - Bit 15 of the third register enables interpolation path one.
// - Bit 14 of the third register enables interpolation path two.
// - Bit 9 of the third register enables decimation path one.
// - Bit 8 of the third register enables decimation path two.
// - Bit 0 of the third register enables the notch filter.
// - Notch coefficients follow automatically from the rates in use.
// - Notch off gives widest passband, weaker stopband; notch on recommended.
// - Path enable refused when core clock has too few cycles per sample.
// - A refused enable leaves running paths untouched.
// - A refused enable raises an underclock error seen on pins and interrupts; the code drives only the underclock_err pin and status bit 0, no interrupt.
package irc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte address is four times the printed index
  localparam logic [11:0] IRC_IDX_C1_HIGH   = 12'hef0;
  localparam logic [11:0] IRC_IDX_C1_LOW    = 12'hef1;
  localparam logic [11:0] IRC_IDX_C1_EN     = 12'hef2;
  localparam logic [11:0] IRC_IDX_C2_HIGH   = 12'hef3;
  localparam logic [11:0] IRC_IDX_C2_LOW    = 12'hef4;
  localparam logic [11:0] IRC_IDX_C2_EN     = 12'hef5;
  localparam logic [11:0] IRC_IDX_STATUS    = 12'hef6;
  localparam logic [11:0] IRC_IDX_CORE_RATE = 12'hef7;
  localparam logic [11:0] IRC_IDX_ASYNC_RATE = 12'hef8;
  localparam logic [11:0] IRC_IDX_BUDGET    = 12'hef9;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int IRC_SEL_LSB     = 11;
  localparam int IRC_SEL_MSB     = 14;
  localparam int IRC_INT1_BIT    = 15;
  localparam int IRC_INT2_BIT    = 14;
  localparam int IRC_DEC1_BIT    = 9;
  localparam int IRC_DEC2_BIT    = 8;
  localparam int IRC_NOTCH_BIT   = 0;
  localparam logic [15:0] IRC_EN_MASK = 16'hc301;

  ////////////////////////////////////////////////////////////////////////////
  // Rate codes and reset values
  localparam logic [3:0] IRC_CODE_CORE1  = 4'h0;
  localparam logic [3:0] IRC_CODE_CORE2  = 4'h1;
  localparam logic [3:0] IRC_CODE_CORE3  = 4'h2;
  localparam logic [3:0] IRC_CODE_ASYNC1 = 4'h8;
  localparam logic [3:0] IRC_CODE_ASYNC2 = 4'h9;
  localparam logic [15:0] IRC_RST_SEL    = 16'h0000;
  localparam logic [15:0] IRC_RST_EN     = 16'h0000;
  localparam logic [4:0]  IRC_RST_RATE   = 5'h06;   // 48 kHz in 8 kHz units
  localparam logic [4:0]  IRC_MIN_RATE   = 5'h01;   // 8 kHz
  localparam logic [4:0]  IRC_MAX_RATE   = 5'h18;   // 192 kHz
  localparam logic [2:0]  IRC_MAX_RATIO  = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // Clock budget: core cycles in one 8 kHz sample period
  localparam int IRC_CLK_HZ        = 20000000;
  localparam int IRC_BASE_RATE_HZ  = 8000;
  localparam int IRC_CYC_PER_BASE  = IRC_CLK_HZ / IRC_BASE_RATE_HZ;
  localparam logic [15:0] IRC_CYC_PER_PATH = 16'h0020;
  localparam logic [15:0] IRC_RST_BUDGET   = 16'h0000;

  localparam logic [1:0] IRC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] IRC_RESP_SLVERR = 2'b10;

  // One audio sample moving through a path
  typedef struct packed {
    logic        valid;
    logic [23:0] data;
  } irc_sample_type;

  // Per-converter decoded rate state
  typedef struct packed {
    logic       ok;
    logic [4:0] low;
    logic [4:0] high;
  } irc_rates_type;

endpackage : irc_pkg
